// ---- design/ascii_command_parser.sv ----
// Purpose: Frames and decodes ASCII command lines and sends framed replies.
// Assumes: Received characters come from logic on the same clock.
// Notes:   The power-down input is an outside level and is filtered.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - A hash character starts every command line.
// - Every reply ends with CR then LF.
// - Argument digits are 0-9 or A-F only.
// - Fewer than two digits is not valid.
// - Digits are group, subgroup, command, setting.
// - Setting is one hex digit normally.
// - Main-port baud setting 5 means 9600, default.
// - Every reply starts with a hash character.
// - Done on success, Error on failure.
// - Queries reply tag, literal space, value.
// - Command 01 enters command mode, replies Done.
// - Command 00 returns data mode, replies Done.
// - Command 505 reports version and serial number.
// - Command 520 reports power-fail tag, space, flag.
// - Power down sets flag; 63 or 65 clear.
module ascii_command_parser
   import ascii_command_parser_pkg::*;
#(
   parameter logic [63:0] VERSION_TEXT = 64'h5665_7220_312E_3030, // Arbitrary value.
   parameter logic [63:0] SERIAL_TEXT  = 64'h534E_3132_3334_3536  // Arbitrary value.
)(
   input  wire logic       clock_in,
   input  wire logic       resetn_in,
   input  wire logic       enable_in,
   input  wire logic [7:0] rx_data_in,
   input  wire logic       rx_valid_in,
   output logic            rx_ready_out,
   output logic [7:0]      tx_data_out,
   output logic            tx_valid_out,
   input  wire logic       tx_ready_in,
   input  wire logic       power_down_in,
   output logic            command_mode_out,
   output logic [3:0]      baud_sel_out,
   output logic            power_fail_out,
   output logic            reset_reader_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // State and storage.
   parse_state_type          state_q;
   logic [3:0]               digit_q [MAX_DIGITS];
   logic [3:0]               count_q;
   logic                     bad_q;
   logic [MSG_BITS-1:0]      msg_q;
   logic [4:0]               left_q;
   logic [7:0]               tx_data_q;
   logic                     mode_q;
   logic [3:0]               baud_q;
   logic                     pfail_q;
   logic                     reset_pulse_q;
   logic [2:0]               pdn_sync_q;
   logic                     pdn_stable_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Character classification.
   wire       rx_take   = rx_valid_in && rx_ready_out;
   wire       is_som    = rx_data_in == SOM_CHAR;
   wire       is_cr     = rx_data_in == CR_CHAR;
   wire       is_num    = rx_data_in >= DIGIT_0_CHAR && rx_data_in <= DIGIT_9_CHAR;
   wire       is_letter = rx_data_in >= LETTER_A_CHAR && rx_data_in <= LETTER_F_CHAR;
   wire       is_hex    = is_num || is_letter;
   wire [7:0] nib_wide  = is_num ? rx_data_in - DIGIT_0_CHAR
                                 : rx_data_in - LETTER_BIAS;
   wire [3:0] nibble    = nib_wide[3:0];
   wire       full      = count_q == 4'(MAX_DIGITS);

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode, valid only on a clean line of two or more digits.
   wire       line_ok   = !bad_q && count_q >= 4'h2;
   wire       len2      = line_ok && count_q == 4'h2;
   wire       len3      = line_ok && count_q == 4'h3;
   wire       len4      = line_ok && count_q == 4'h4;
   wire       cmd_01    = len2 && digit_q[0] == 4'h0 && digit_q[1] == 4'h1;
   wire       cmd_00    = len2 && digit_q[0] == 4'h0 && digit_q[1] == 4'h0;
   wire       cmd_63    = len2 && digit_q[0] == 4'h6 && digit_q[1] == 4'h3;
   wire       cmd_65    = len2 && digit_q[0] == 4'h6 && digit_q[1] == 4'h5;
   wire       cmd_505   = len3 && digit_q[0] == 4'h5 && digit_q[1] == 4'h0
                               && digit_q[2] == 4'h5;
   wire       cmd_520   = len3 && digit_q[0] == 4'h5 && digit_q[1] == 4'h2
                               && digit_q[2] == 4'h0;
   // Group, subgroup, command, then the setting digit.
   wire       cmd_baud  = len4 && digit_q[0] == GROUP_PORT
                               && digit_q[1] == SUBGROUP_MAIN
                               && digit_q[2] == CMD_BAUD;
   wire       cmd_done  = cmd_01 || cmd_00 || cmd_63 || cmd_65 || cmd_baud;
   wire       executing = state_q == ST_EXECUTE;

   ////////////////////////////////////////////////////////////////////////////////
   // Reply images, left aligned; every one opens with the hash character
   // and closes with CR LF.
   wire [7:0] pf_digit = pfail_q ? DIGIT_0_CHAR + 8'h01 : DIGIT_0_CHAR;
   wire [MSG_BITS-1:0] msg_done  = {SOM_CHAR, DONE_TEXT, CR_CHAR, LF_CHAR,
                                    104'h0};
   wire [MSG_BITS-1:0] msg_error = {SOM_CHAR, ERROR_TEXT, CR_CHAR, LF_CHAR,
                                    96'h0};
   wire [MSG_BITS-1:0] msg_pfail = {SOM_CHAR, POWER_FAIL_REPLY_TAG, SPACE_CHAR,
                                    pf_digit, CR_CHAR, LF_CHAR, 88'h0};
   wire [MSG_BITS-1:0] msg_vers  = {SOM_CHAR, VERSION_TEXT, SPACE_CHAR,
                                    SERIAL_TEXT, CR_CHAR, LF_CHAR};
   wire [MSG_BITS-1:0] msg_next  = cmd_done ? msg_done
                                 : cmd_520  ? msg_pfail
                                 : cmd_505  ? msg_vers
                                 : msg_error;
   wire [4:0]          len_next  = cmd_done ? 5'(DONE_LEN)
                                 : cmd_520  ? 5'(PFAIL_LEN)
                                 : cmd_505  ? 5'(VERSION_LEN)
                                 : 5'(ERROR_LEN);

   ////////////////////////////////////////////////////////////////////////////////
   // Handshakes; no new character is taken while a reply is going out.
   wire tx_take = tx_valid_out && tx_ready_in;
   assign rx_ready_out     = state_q == ST_HUNT || state_q == ST_COLLECT;
   assign tx_valid_out     = state_q == ST_SEND;
   assign tx_data_out      = tx_data_q;
   assign command_mode_out = mode_q;
   assign baud_sel_out     = baud_q;
   assign power_fail_out   = pfail_q;
   assign reset_reader_out = reset_pulse_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Power-down filter: a change counts once the last two stages agree.
   wire pdn_agree = pdn_sync_q[1] == pdn_sync_q[2];
   wire pdn_event = pdn_agree && pdn_sync_q[2] && !pdn_stable_q;
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pdn_sync_q   <= 3'h0;
         pdn_stable_q <= 1'b0;
      end else if (enable_in) begin
         pdn_sync_q <= {pdn_sync_q[1:0], power_down_in};
         if (pdn_agree) begin
            pdn_stable_q <= pdn_sync_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Settings change only on a recognised line. A power-down event that
   // meets a clearing command in the same cycle keeps the flag set.
   wire pf_clear = executing && (cmd_63 || cmd_65);
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_q        <= COMMAND_MODE_RST;
         baud_q        <= BAUD_9600_SEL;
         pfail_q       <= 1'b0;
         reset_pulse_q <= 1'b0;
      end else if (enable_in) begin
         pfail_q       <= pdn_event || (pfail_q && !pf_clear);
         reset_pulse_q <= executing && cmd_63;
         if (executing && cmd_01) begin
            mode_q <= 1'b1;
         end else if (executing && cmd_00) begin
            mode_q <= 1'b0;
         end
         if (executing && cmd_baud) begin
            baud_q <= digit_q[3];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Line capture. A hash anywhere restarts the line, so a lost CR costs
   // only the broken line, not the next one.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= ST_HUNT;
         count_q <= 4'h0;
         bad_q   <= 1'b0;
         for (int i = 0; i < MAX_DIGITS; i++) begin
            digit_q[i] <= 4'h0;
         end
      end else if (enable_in) begin
         case (state_q)
            ST_HUNT: begin
               if (rx_take && is_som) begin
                  state_q <= ST_COLLECT;
                  count_q <= 4'h0;
                  bad_q   <= 1'b0;
               end
            end
            ST_COLLECT: begin
               if (rx_take && is_som) begin
                  count_q <= 4'h0;
                  bad_q   <= 1'b0;
               end else if (rx_take && is_cr) begin
                  state_q <= ST_EXECUTE;
               end else if (rx_take && (!is_hex || full)) begin
                  bad_q <= 1'b1;
               end else if (rx_take) begin
                  digit_q[count_q[2:0]] <= nibble;
                  count_q               <= count_q + 4'h1;
               end
            end
            ST_EXECUTE: begin
               state_q <= ST_SEND;
            end
            ST_SEND: begin
               if (tx_take && left_q == 5'h1) begin
                  state_q <= ST_HUNT;
               end
            end
            default: begin
               state_q <= ST_HUNT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reply shifter: the image is latched once, so a flag change mid-reply
   // cannot tear the value being sent.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         msg_q     <= '0;
         left_q    <= 5'h0;
         tx_data_q <= 8'h00;
      end else if (enable_in) begin
         if (executing) begin
            msg_q     <= {msg_next[MSG_BITS-9:0], 8'h00};
            left_q    <= len_next;
            tx_data_q <= msg_next[MSG_BITS-1 -: 8];
         end else if (tx_take) begin
            msg_q     <= {msg_q[MSG_BITS-9:0], 8'h00};
            left_q    <= left_q - 5'h1;
            tx_data_q <= msg_q[MSG_BITS-1 -: 8];
         end
      end
   end

endmodule : ascii_command_parser
`default_nettype wire

// ---- inc/ascii_command_parser_pkg.sv ----
// Purpose: Constants shared by the serial ASCII command interpreter.
// Assumes: Eight-bit characters delivered one per handshake.
// Notes:   Message texts are kept as packed byte strings, first byte in the top bits.
`default_nettype none
package ascii_command_parser_pkg;

   // Framing characters.
   localparam logic [7:0] SOM_CHAR   = 8'h23;
   localparam logic [7:0] CR_CHAR    = 8'h0D;
   localparam logic [7:0] LF_CHAR    = 8'h0A;
   localparam logic [7:0] SPACE_CHAR = 8'h20;

   // Character ranges accepted as hexadecimal digits.
   localparam logic [7:0] DIGIT_0_CHAR  = 8'h30;
   localparam logic [7:0] DIGIT_9_CHAR  = 8'h39;
   localparam logic [7:0] LETTER_A_CHAR = 8'h41;
   localparam logic [7:0] LETTER_F_CHAR = 8'h46;
   localparam logic [7:0] LETTER_BIAS   = 8'h37;

   // Reply texts.
   localparam logic [31:0] DONE_TEXT            = 32'h446F_6E65;
   localparam logic [39:0] ERROR_TEXT           = 40'h45_7272_6F72;
   localparam logic [31:0] POWER_FAIL_REPLY_TAG = 32'h5057_5242;

   // Reply lengths in characters, line ending included.
   localparam int MSG_BITS     = 160;
   localparam int DONE_LEN     = 7;
   localparam int ERROR_LEN    = 8;
   localparam int PFAIL_LEN    = 9;
   localparam int VERSION_LEN  = 20;

   // Command line capacity and digit codes.
   localparam int             MAX_DIGITS       = 8;
   localparam logic [3:0]     GROUP_PORT       = 4'h1;
   localparam logic [3:0]     SUBGROUP_MAIN    = 4'h0;
   localparam logic [3:0]     CMD_BAUD         = 4'h0;
   localparam logic [3:0]     BAUD_9600_SEL    = 4'h5;
   localparam logic           COMMAND_MODE_RST = 1'b0;

   // Parser states, Gray coded along hunt, collect, execute, send.
   typedef enum logic [1:0] {
      ST_HUNT    = 2'b00,
      ST_COLLECT = 2'b01,
      ST_EXECUTE = 2'b11,
      ST_SEND    = 2'b10
   } parse_state_type;

endpackage : ascii_command_parser_pkg
`default_nettype wire

// ---- tb/ascii_command_parser_properties.sv ----
// Purpose: Port timing properties of the ASCII command parser.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Attached by the bind statement at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module ascii_command_parser_properties
   import ascii_command_parser_pkg::*;
(
   input wire logic       clock_in,
   input wire logic       resetn_in,
   input wire logic       enable_in,
   input wire logic [7:0] rx_data_in,
   input wire logic       rx_valid_in,
   input wire logic       rx_ready_out,
   input wire logic [7:0] tx_data_out,
   input wire logic       tx_valid_out,
   input wire logic       tx_ready_in,
   input wire logic       power_down_in,
   input wire logic       command_mode_out,
   input wire logic [3:0] baud_sel_out,
   input wire logic       power_fail_out,
   input wire logic       reset_reader_out
);
   // Qualified transfers; the line-ending take is what launches execution.
   // A CR closes a line only after a hash has opened one; a stray CR is noise.
   wire logic rx_take = enable_in && rx_valid_in && rx_ready_out;
   logic      line_open_q;
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         line_open_q <= 1'b0;
      end else if (rx_take) begin
         line_open_q <= rx_data_in == SOM_CHAR || (line_open_q && rx_data_in != CR_CHAR);
      end
   end
   wire logic cr_take = rx_take && line_open_q && rx_data_in == CR_CHAR;
   wire logic tx_take = enable_in && tx_valid_out && tx_ready_in;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   // A closed line gives one quiet execute cycle, then the reply opens.
   sequence reply_open_s;
      !rx_ready_out ##1 (tx_valid_out && tx_data_out == SOM_CHAR);
   endsequence
   // Settings may only move two edges after a line was closed.
   reply_hash_a: assert property ($rose(tx_valid_out) |-> tx_data_out == SOM_CHAR)
      else $error("reply does not open with hash");
   reply_cr_lf_a: assert property (tx_take && tx_data_out == CR_CHAR |=>
      tx_valid_out && tx_data_out == LF_CHAR) else $error("CR not followed by LF");
   reply_end_a: assert property (tx_take && tx_data_out == LF_CHAR |=>
      !tx_valid_out && rx_ready_out) else $error("reply runs past LF");
   rx_closed_a: assert property (tx_valid_out |-> !rx_ready_out)
      else $error("input open during reply");
   line_close_a: assert property (cr_take |=> reply_open_s)
      else $error("CR did not start a reply");
   tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_data_out)) else $error("stalled byte changed");
   setting_cause_a: assert property ($changed(baud_sel_out) || $changed(command_mode_out)
      |-> $past(cr_take, 2)) else $error("setting moved without a command");
   pulse_once_a: assert property (reset_reader_out |-> $past(cr_take, 2)
      ##1 !reset_reader_out) else $error("reset pulse malformed");
   flag_clear_a: assert property ($fell(power_fail_out) |-> $past(cr_take, 2))
      else $error("flag cleared without a command");
   flag_set_a: assert property (enable_in && $rose(power_down_in) |-> ##[1:8] power_fail_out)
      else $error("power down not flagged");
endmodule : ascii_command_parser_properties
bind ascii_command_parser ascii_command_parser_properties u_props (.clock_in, .resetn_in,
   .enable_in, .rx_data_in, .rx_valid_in, .rx_ready_out, .tx_data_out, .tx_valid_out,
   .tx_ready_in, .power_down_in, .command_mode_out, .baud_sel_out, .power_fail_out,
   .reset_reader_out);
`default_nettype wire

// ---- tb/host_model.sv ----
// Purpose: Host terminal that sends command lines and collects replies.
// Assumes: Inputs of the parser are driven at the falling edge.
// Notes:   The reply sink stalls at random to exercise held bytes.
`timescale 1ns/100ps
`default_nettype none
module host_model
   import ascii_command_parser_pkg::*;
(
   input wire logic        clock_in,
   output var logic [7:0]  rx_data_out = 8'h00,
   output var logic        rx_valid_out = 1'b0,
   input wire logic        rx_ready_in,
   input wire logic [7:0]  tx_data_in,
   input wire logic        tx_valid_in,
   output var logic        tx_ready_out = 1'b0,
   output var logic [159:0] reply_out = '0
);
   integer seed = 32'hE754;
   ////////////////////////////////////////////////////////////
   // Sink stalls one cycle in four, as a slow terminal would.
   always @(negedge clock_in) tx_ready_out <= ($random(seed) & 3) != 0;
   // A new line being offered clears the previous reply, so one process owns it.
   always @(posedge clock_in) begin
      if (tx_valid_in && tx_ready_out) begin
         reply_out <= {reply_out[151:0], tx_data_in};
      end else if (rx_valid_out) begin
         reply_out <= '0;
      end
   end
   // Each character is held until the edge that takes it; the host ends with CR.
   task automatic send_line(input string s);
      int n;
      for (int i = 0; i <= s.len(); i++) begin
         @(negedge clock_in);
         rx_data_out = (i == s.len()) ? CR_CHAR : s[i];
         rx_valid_out = 1'b1;
         while (!rx_ready_in) @(negedge clock_in);
         @(posedge clock_in);
      end
      @(negedge clock_in);
      rx_valid_out = 1'b0;
      rx_data_out = ~rx_data_out; // Released data must not look valid.
      n = 0;
      while (!tx_valid_in && n < 50) begin
         @(negedge clock_in);
         n++;
      end
      while (tx_valid_in && n < 400) begin
         @(negedge clock_in);
         n++;
      end
   endtask : send_line
endmodule : host_model
`default_nettype wire

// ---- tb/ascii_command_parser_tb.sv ----
// Purpose: Self-checking bench for the ASCII command parser.
// Assumes: Enable drops only while both links are idle; the host model drives them.
// Notes:   Baud digits are drawn at random from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
module ascii_command_parser_tb
   import ascii_command_parser_pkg::*;
;
   localparam logic [63:0] VER_TEXT = 64'h5665_7220_322E_3130; // Arbitrary value.
   localparam logic [63:0] SER_TEXT = 64'h4E55_4D30_3030_3037; // Arbitrary value.
   logic         clock_in = 1'b0;
   logic         resetn_in = 1'b0;
   logic         power_down_in = 1'b0;
   logic         enable = 1'b1;
   logic [7:0]   rx_data, tx_data;
   logic         rx_valid, rx_ready, tx_valid, tx_ready, mode, pfail, pulse;
   logic [3:0]   baud;
   logic [159:0] reply;
   integer       seed = 32'hE754;
   int           n_mismatch = 0;
   int           checks_done = 0;
   int           pulses = 0;
   string        bad_lines [4] = '{"#1", "#10a5", "#123456789", "#77"};
   ////////////////////////////////////////////////////////////
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) if (pulse) pulses++;
   ascii_command_parser #(.VERSION_TEXT(VER_TEXT), .SERIAL_TEXT(SER_TEXT)) u_ascii_command_parser (
      .clock_in(clock_in), .resetn_in(resetn_in), .enable_in(enable), .rx_data_in(rx_data),
      .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .tx_data_out(tx_data),
      .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .power_down_in(power_down_in),
      .command_mode_out(mode), .baud_sel_out(baud), .power_fail_out(pfail),
      .reset_reader_out(pulse));
   host_model u_host_model (.clock_in(clock_in), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
      .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
      .tx_ready_out(tx_ready), .reply_out(reply));
   // Expected replies, built from the framing constants.
   function automatic logic [159:0] ack(input logic ok);
      return ok ? {SOM_CHAR, DONE_TEXT, CR_CHAR, LF_CHAR} : {SOM_CHAR, ERROR_TEXT, CR_CHAR, LF_CHAR};
   endfunction : ack
   function automatic logic [159:0] flag_reply(input logic f);
      return {SOM_CHAR, POWER_FAIL_REPLY_TAG, SPACE_CHAR, DIGIT_0_CHAR | {7'h00, f}, CR_CHAR, LF_CHAR};
   endfunction : flag_reply
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? DIGIT_0_CHAR + {4'h0, n} : LETTER_A_CHAR + {4'h0, n} - 8'h0A;
   endfunction : hex_char
   task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cmd(input string s, input logic [159:0] exp);
      u_host_model.send_line(s);
      check(s, reply, exp);
      $display("test %s done", s);
   endtask : cmd
   // With the enable low the whole blip is frozen out, so the flag must stay clear.
   task automatic power_blip(input logic en);
      enable = en;
      power_down_in = 1'b1;
      repeat (10) @(negedge clock_in);
      power_down_in = 1'b0;
      repeat (10) @(negedge clock_in);
      enable = 1'b1;
      check("flag", pfail, en);
      $display("test power blip enable %0d done", en);
   endtask : power_blip
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////
   // Main sequence; a noisy prefix and malformed lines come first.
   initial begin
      logic [3:0] d;
      repeat (5) @(negedge clock_in);
      resetn_in = 1'b1;
      check("baud", baud, BAUD_9600_SEL);
      cmd("xy#01", ack(1'b1));
      check("mode", mode, 1'b1);
      for (int i = 0; i < 4; i++) begin
         cmd(bad_lines[i], ack(1'b0));
         check("baud", baud, BAUD_9600_SEL);
      end
      for (int i = 0; i < 4; i++) begin
         d = 4'($random(seed));
         cmd($sformatf("#100%c", hex_char(d)), ack(1'b1));
         check("baud", baud, d);
      end
      power_blip(1'b1);
      cmd("#520", flag_reply(1'b1));
      cmd("#65", ack(1'b1));
      check("flag", pfail, 1'b0);
      power_blip(1'b1);
      cmd("#63", ack(1'b1));
      check("flag", pfail, 1'b0);
      check("pulses", pulses, 1);
      power_blip(1'b0);
      cmd("#520", flag_reply(1'b0));
      cmd("#505", {SOM_CHAR, VER_TEXT, SPACE_CHAR, SER_TEXT, CR_CHAR, LF_CHAR});
      cmd("#00", ack(1'b1));
      check("mode", mode, 1'b0);
      tally_and_finish();
   end
   // The whole run needs a few hundred cycles; this limit leaves ample room.
   initial begin
      repeat (20000) @(posedge clock_in);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : ascii_command_parser_tb
`default_nettype wire
